// ### design/dtaf_device.sv
`default_nettype none
module dtaf_device
  import dtaf_pkg::*;
#(
  parameter logic [3:0]  DEVICE_TYPE_ID = 4'h6, // arbitrary value
  parameter int unsigned WRITE_CYCLES   = RF_WRITE_CYCLES
)(
  // clock and control
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              ce,
  // serial link
  dtaf_link_if.device            link,
  // supply and field monitors
  input  wire logic              vcc_ok,
  input  wire logic              field_ok,
  // contactless word port
  input  wire logic              rf_rd,
  input  wire logic              rf_wr,
  input  wire logic [RF_AW-1:0]  rf_addr,
  input  wire logic [31:0]       rf_wdata,
  output logic      [31:0]       rf_rdata,
  input  wire logic              rf_cmd_active,
  // contactless coding
  input  wire logic              rf_downlink_1of4,
  input  wire logic              rf_high_rate,
  input  wire logic              rf_two_sub,
  input  wire logic              rf_fast_cmd,
  output logic      [8:0]        rf_slots,
  output dtaf_rate_t             rf_reply_rate,
  output logic                   rf_reply_two_sub,
  output logic                   rf_fast_refused,
  // activity indicator
  input  wire dtaf_activity_t    activity_select,
  output logic                   rf_activity_out,
  output logic                   rf_activity_oe_n,
  // energy harvest
  input  wire logic              harvest_enable,
  input  wire logic              harvest_request,
  output logic                   harvest_active,
  output logic                   harvest_oe_n
);
  localparam int unsigned WCW = $clog2(WRITE_CYCLES + 1);

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX   = 5'h02,
    ST_ACK  = 5'h04,
    ST_TX   = 5'h08,
    ST_RACK = 5'h10
  } dtaf_dev_state_t;
  typedef enum logic [1:0] {K_SEL = 2'h0, K_ADH = 2'h1, K_ADL = 2'h2, K_DAT = 2'h3} dtaf_kind_t;

  logic [7:0]      mem [MEM_BYTES];
  logic [3:0]      s1;
  logic [3:0]      s2;
  logic            scl_d;
  logic            sda_d;
  logic            scl_q;
  logic            sda_q;
  logic            vcc_q;
  logic            field_q;
  logic            start_ev;
  logic            stop_ev;
  logic            scl_rise;
  logic            scl_fall;
  logic            sel_ok;
  logic            byte_end;
  logic            i2c_wr;
  logic            wr_busy;
  logic [WCW-1:0]  wcnt;
  dtaf_dev_state_t state;
  dtaf_kind_t      kind;
  logic [3:0]      bitcnt;
  logic [7:0]      shift;
  logic            rw;
  logic            mack;
  logic [MEM_AW-1:0] addr;
  logic            sda_oe_n;
  logic            sda_out;

  // pins from outside the clock domain
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s1    <= 4'h3;
      s2    <= 4'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else if (ce)
    begin
      s1    <= {field_ok, vcc_ok, link.sda, link.scl};
      s2    <= s1;
      scl_d <= s2[0];
      sda_d <= s2[1];
    end
  end

  assign scl_q    = s2[0];
  assign sda_q    = s2[1];
  assign vcc_q    = s2[2];
  assign field_q  = s2[3];
  assign start_ev = scl_q & scl_d & sda_d & ~sda_q;
  assign stop_ev  = scl_q & scl_d & ~sda_d & sda_q;
  assign scl_rise = scl_q & ~scl_d;
  assign scl_fall = ~scl_q & scl_d;
  assign sel_ok   = shift[7:SEL_ID_LSB] == DEVICE_TYPE_ID
                    && shift[SEL_BANK] == BANK_USER && shift[2:1] == SEL_FIXED;
  assign byte_end = state == ST_RX && scl_fall && bitcnt == 4'h8;
  assign i2c_wr   = byte_end && kind == K_DAT && !stop_ev && !start_ev;
  assign wr_busy  = wcnt != '0;

  // serial slave, sampling on rising and driving after falling clock
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state    <= ST_IDLE;
      kind     <= K_SEL;
      bitcnt   <= 4'h0;
      shift    <= 8'h00;
      rw       <= 1'b0;
      mack     <= 1'b0;
      addr     <= '0;
      sda_oe_n <= 1'b1;
    end
    else if (ce)
    begin
      if (stop_ev)
      begin
        state    <= ST_IDLE;
        sda_oe_n <= 1'b1;
      end
      else if (start_ev)
      begin
        state    <= ST_RX;
        kind     <= K_SEL;
        bitcnt   <= 4'h0;
        sda_oe_n <= 1'b1;
      end
      else
        unique case (state)
          ST_IDLE:
            bitcnt <= 4'h0;
          ST_RX:
            if (scl_rise)
            begin
              shift  <= {shift[6:0], sda_q};
              bitcnt <= bitcnt + 4'h1;
            end
            else if (byte_end)
            begin
              state    <= ST_ACK;
              sda_oe_n <= 1'b0;
              unique case (kind)
                K_SEL:
                  if (sel_ok)
                  begin
                    rw   <= shift[0];
                    kind <= K_ADH;
                  end
                  else
                  begin
                    state    <= ST_IDLE;
                    sda_oe_n <= 1'b1;
                  end
                K_ADH:
                begin
                  addr[MEM_AW-1:8] <= shift[MEM_AW-9:0];
                  kind             <= K_ADL;
                end
                K_ADL:
                begin
                  addr[7:0] <= shift;
                  kind      <= K_DAT;
                end
                K_DAT:
                  addr <= addr + 1'b1;
              endcase
            end
          ST_ACK:
            if (scl_fall)
            begin
              bitcnt <= 4'h0;
              if (rw)
              begin
                state    <= ST_TX;
                shift    <= mem[addr];
                sda_oe_n <= mem[addr][7];
                addr     <= addr + 1'b1;
              end
              else
              begin
                state    <= ST_RX;
                sda_oe_n <= 1'b1;
              end
            end
          ST_TX:
            if (scl_rise)
              bitcnt <= bitcnt + 4'h1;
            else if (scl_fall)
            begin
              if (bitcnt == 4'h8)
              begin
                state    <= ST_RACK;
                sda_oe_n <= 1'b1;
              end
              else
              begin
                shift    <= {shift[6:0], 1'b0};
                sda_oe_n <= shift[6];
              end
            end
          ST_RACK:
            if (scl_rise)
              mack <= ~sda_q;
            else if (scl_fall)
            begin
              bitcnt <= 4'h0;
              if (mack)
              begin
                state    <= ST_TX;
                shift    <= mem[addr];
                sda_oe_n <= mem[addr][7];
                addr     <= addr + 1'b1;
              end
              else
                state <= ST_IDLE;
            end
        endcase
    end
  end

  // one array seen as bytes and as words; contactless write wins a clash
  always_ff @(posedge clock)
  begin
    if (ce)
    begin
      if (rf_wr && !wr_busy)
        for (int i = 0; i < 4; i++)
          mem[{rf_addr, 2'(i)}] <= rf_wdata[8*i +: 8];
      else if (i2c_wr)
        mem[addr] <= shift;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      rf_rdata <= 32'h0;
    else if (ce && rf_rd)
      for (int i = 0; i < 4; i++)
        rf_rdata[8*i +: 8] <= mem[{rf_addr, 2'(i)}];
  end

  // contactless write cycle timer; contactless writes during it are dropped, serial writes are not
  always_ff @(posedge clock)
  begin
    if (rst)
      wcnt <= '0;
    else if (ce)
    begin
      if (rf_wr && !wr_busy)
        wcnt <= WCW'(WRITE_CYCLES);
      else if (wr_busy)
        wcnt <= wcnt - 1'b1;
    end
  end

  // indicator only pulls low; pull-up gives the idle level
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rf_activity_out  <= 1'b0;
      rf_activity_oe_n <= 1'b1;
    end
    else if (ce)
    begin
      rf_activity_out <= 1'b0;
      if (!vcc_q)
        rf_activity_oe_n <= 1'b1;
      else if (activity_select == write_activity_setting)
        rf_activity_oe_n <= ~wr_busy;
      else
        rf_activity_oe_n <= ~rf_cmd_active;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      harvest_active <= 1'b0;
      harvest_oe_n   <= 1'b1;
    end
    else if (ce)
    begin
      if (!harvest_enable || !field_q)
      begin
        harvest_active <= 1'b0;
        harvest_oe_n   <= 1'b1;
      end
      else if (harvest_request)
      begin
        harvest_active <= 1'b1;
        harvest_oe_n   <= 1'b0;
      end
    end
  end

  // coding selection reported to the analog front
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rf_slots         <= SLOTS_1OF256;
      rf_reply_rate    <= RATE_LOW;
      rf_reply_two_sub <= 1'b0;
      rf_fast_refused  <= 1'b0;
    end
    else if (ce)
    begin
      rf_slots        <= rf_downlink_1of4 ? SLOTS_1OF4 : SLOTS_1OF256;
      rf_fast_refused <= rf_fast_cmd && (!rf_high_rate || rf_two_sub);
      if (rf_fast_cmd && rf_high_rate && !rf_two_sub)
      begin
        rf_reply_rate    <= RATE_FAST;
        rf_reply_two_sub <= 1'b0;
      end
      else
      begin
        rf_reply_rate    <= rf_high_rate ? RATE_HIGH : RATE_LOW;
        rf_reply_two_sub <= rf_two_sub;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      sda_out <= 1'b0;
    else if (ce)
      sda_out <= 1'b0;
  end

  assign link.sda_s_out  = sda_out;
  assign link.sda_s_oe_n = sda_oe_n;
endmodule
`default_nettype wire

// ### pkg/dtaf_pkg.sv
`default_nettype none
package dtaf_pkg;
  // clock and link timing
  localparam real         CLK_PERIOD_NS      = 100.0;
  localparam real         LINK_PERIOD_NS     = 4000.0;
  localparam int unsigned SCL_QUARTER_CYCLES = int'(LINK_PERIOD_NS / (4.0 * CLK_PERIOD_NS));
  localparam real         RF_WRITE_TIME_MS   = 5.75;
  localparam int unsigned RF_WRITE_CYCLES    = int'($ceil(RF_WRITE_TIME_MS * 1.0e6 / CLK_PERIOD_NS));
  // memory organisation
  localparam int unsigned MEM_BYTES = 2048;
  localparam int unsigned MEM_AW    = 11;
  localparam int unsigned RF_WORDS  = 512;
  localparam int unsigned RF_AW     = 9;
  // select byte fields
  localparam int unsigned SEL_ID_LSB = 4;
  localparam int unsigned SEL_BANK   = 3;
  localparam logic        BANK_USER  = 1'b0;
  localparam logic [1:0]  SEL_FIXED  = 2'h3;
  // downlink pulse position slots
  localparam logic [8:0] SLOTS_1OF4   = 9'h004;
  localparam logic [8:0] SLOTS_1OF256 = 9'h100;
  typedef enum logic [1:0] {RATE_LOW = 2'h0, RATE_HIGH = 2'h1, RATE_FAST = 2'h2} dtaf_rate_t;
  typedef enum logic {write_activity_setting = 1'b0, command_activity_setting = 1'b1} dtaf_activity_t;
  // host controller registers
  localparam logic [7:0]  OFF_CMD        = 8'h00;
  localparam logic [7:0]  OFF_STATUS     = 8'h04;
  localparam logic [7:0]  OFF_INT_STATUS = 8'h08;
  localparam logic [7:0]  OFF_INT_CLEAR  = 8'h0c;
  localparam logic [7:0]  OFF_INT_ENABLE = 8'h10;
  localparam int unsigned CMD_CODE_LSB   = 0;
  localparam int unsigned CMD_ACK_BIT    = 2;
  localparam int unsigned CMD_DATA_LSB   = 8;
  localparam int unsigned STAT_BUSY_BIT  = 0;
  localparam int unsigned STAT_NACK_BIT  = 1;
  localparam int unsigned STAT_RX_LSB    = 8;
  localparam int unsigned INT_DONE_BIT   = 0;
  localparam int unsigned INT_NACK_BIT   = 1;
  typedef enum logic [1:0] {CMD_START = 2'h0, CMD_STOP = 2'h1, CMD_WRITE = 2'h2, CMD_READ = 2'h3} dtaf_cmd_t;
endpackage
`default_nettype wire

// ### pkg/dtaf_link_if.sv
`default_nettype none
interface dtaf_link_if;
  logic scl;
  logic sda_m_out;
  logic sda_m_oe_n;
  logic sda_s_out;
  logic sda_s_oe_n;
  logic sda;
  // wired-and line with pull-up
  assign sda = (sda_m_oe_n | sda_m_out) & (sda_s_oe_n | sda_s_out);
  modport host (output scl, sda_m_out, sda_m_oe_n, input sda);
  modport device (input scl, sda, output sda_s_out, sda_s_oe_n);
endinterface
`default_nettype wire

// ### design/dtaf_host.sv
`default_nettype none
module dtaf_host
  import dtaf_pkg::*;
#(
  parameter int unsigned QUARTER = SCL_QUARTER_CYCLES
)(
  // clock and control
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        ce,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // interrupt
  output logic             irq,
  // serial link
  dtaf_link_if.host        link
);
  localparam int unsigned   QW   = $clog2(QUARTER);
  localparam logic [QW-1:0] QMAX = QW'(QUARTER - 1);

  typedef enum logic [3:0] {
    H_IDLE  = 4'h1,
    H_START = 4'h2,
    H_BYTE  = 4'h4,
    H_STOP  = 4'h8
  } dtaf_host_state_t;

  dtaf_host_state_t state;
  logic [QW-1:0]    qcnt;
  logic [1:0]       qtr;
  logic [3:0]       bitn;
  logic [8:0]       txv;
  logic [8:0]       rxv;
  logic             is_read;
  logic             scl_o;
  logic             sda_oe_n;
  logic             sda_out;
  logic             s1;
  logic             sda_q;
  logic [7:0]       rx_data;
  logic             last_nack;
  logic [1:0]       int_status;
  logic [1:0]       int_enable;
  logic [31:0]      rd_word;
  logic             mapped;
  logic             commit;
  logic             wr_go;
  logic             cmd_go;
  logic             done_ev;
  logic             nack_ev;
  logic [1:0]       clr;
  dtaf_cmd_t        cmd;

  assign commit  = psel && penable && pready;
  assign wr_go   = commit && pwrite && mapped;
  assign cmd_go  = wr_go && paddr == OFF_CMD && state == H_IDLE;
  assign cmd     = dtaf_cmd_t'(pwdata[CMD_CODE_LSB +: 2]);
  assign done_ev = state != H_IDLE && qcnt == QMAX && qtr == 2'h3 && (state != H_BYTE || bitn == 4'h8);
  assign nack_ev = done_ev && state == H_BYTE && !is_read && rxv[0];
  assign clr     = (wr_go && paddr == OFF_INT_CLEAR) ? pwdata[1:0] : 2'h0;

  always_comb
  begin
    rd_word = 32'h0;
    mapped  = 1'b1;
    case (paddr)
      OFF_CMD:
        rd_word = 32'h0;
      OFF_STATUS:
      begin
        rd_word[STAT_BUSY_BIT]       = state != H_IDLE;
        rd_word[STAT_NACK_BIT]       = last_nack;
        rd_word[STAT_RX_LSB +: 8]    = rx_data;
      end
      OFF_INT_STATUS:
        rd_word[1:0] = int_status;
      OFF_INT_CLEAR:
        rd_word = 32'h0;
      OFF_INT_ENABLE:
        rd_word[1:0] = int_enable;
      default:
        mapped = 1'b0;
    endcase
  end

  // one wait state keeps every bus output on a flip-flop
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end
    else if (ce)
    begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready)
      begin
        prdata  <= pwrite ? 32'h0 : rd_word;
        pslverr <= !mapped;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s1    <= 1'b1;
      sda_q <= 1'b1;
    end
    else if (ce)
    begin
      s1    <= link.sda;
      sda_q <= s1;
    end
  end

  // bit engine: four quarters per bit, clock made by division
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state    <= H_IDLE;
      qcnt     <= '0;
      qtr      <= 2'h0;
      bitn     <= 4'h0;
      txv      <= 9'h1ff;
      rxv      <= 9'h000;
      is_read  <= 1'b0;
      scl_o    <= 1'b1;
      sda_oe_n <= 1'b1;
    end
    else if (ce)
    begin
      unique case (state)
        H_IDLE:
          if (cmd_go)
          begin
            qcnt    <= '0;
            qtr     <= 2'h0;
            bitn    <= 4'h0;
            is_read <= cmd == CMD_READ;
            // msb first, ninth slot released for write, own ack for read
            txv <= (cmd == CMD_READ) ? {8'hff, pwdata[CMD_ACK_BIT]}
                                     : {pwdata[CMD_DATA_LSB +: 8], 1'b1};
            unique case (cmd)
              CMD_START: state <= H_START;
              CMD_STOP:  state <= H_STOP;
              CMD_WRITE: state <= H_BYTE;
              CMD_READ:  state <= H_BYTE;
            endcase
          end
        H_START, H_BYTE, H_STOP:
        begin
          qcnt <= (qcnt == QMAX) ? '0 : qcnt + 1'b1;
          if (qcnt == QMAX)
            qtr <= qtr + 2'h1;
          if (qcnt == '0)
            unique case (qtr)
              2'h0:
                sda_oe_n <= (state == H_START) ? 1'b1 : (state == H_STOP) ? 1'b0 : txv[8];
              2'h1:
                scl_o <= 1'b1;
              2'h2:
                if (state == H_START)
                  sda_oe_n <= 1'b0;
                else if (state == H_STOP)
                  sda_oe_n <= 1'b1;
                else
                begin
                  rxv <= {rxv[7:0], sda_q};
                  txv <= {txv[7:0], 1'b1};
                end
              2'h3:
                if (state != H_STOP)
                  scl_o <= 1'b0;
            endcase
          if (qcnt == QMAX && qtr == 2'h3)
          begin
            if (state == H_BYTE && bitn != 4'h8)
              bitn <= bitn + 4'h1;
            else
              state <= H_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rx_data   <= 8'h00;
      last_nack <= 1'b0;
    end
    else if (ce && done_ev && state == H_BYTE)
    begin
      rx_data   <= rxv[8:1];
      last_nack <= rxv[0];
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      int_status <= 2'h0;
      int_enable <= 2'h0;
      irq        <= 1'b0;
      sda_out    <= 1'b0;
    end
    else if (ce)
    begin
      int_status[INT_DONE_BIT] <= done_ev | (int_status[INT_DONE_BIT] & ~clr[INT_DONE_BIT]);
      int_status[INT_NACK_BIT] <= nack_ev | (int_status[INT_NACK_BIT] & ~clr[INT_NACK_BIT]);
      if (wr_go && paddr == OFF_INT_ENABLE)
        int_enable <= pwdata[1:0];
      irq     <= |(int_status & int_enable);
      sda_out <= 1'b0;
    end
  end

  assign link.scl        = scl_o;
  assign link.sda_m_out  = sda_out;
  assign link.sda_m_oe_n = sda_oe_n;
endmodule
`default_nettype wire

// ### verification/dtaf_link_sva.sv
`default_nettype none
module dtaf_link_sva (
  // clock domain
  input wire logic clock,
  input wire logic rst,
  // serial link
  input wire logic scl,
  input wire logic sda_m_out,
  input wire logic sda_m_oe_n,
  input wire logic sda_s_out,
  input wire logic sda_s_oe_n,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // open drain: only ever pulls low
  dev_out_low_a: assert property (sda_s_out == 1'b0)
    else $error("device data not low");
  host_out_low_a: assert property (sda_m_out == 1'b0)
    else $error("host data not low");
  // device data may move only while the clock is low
  dev_edge_low_a: assert property ($changed(sda_s_oe_n) |-> !scl)
    else $error("device data moved with clock high");
  dev_hold_fall_a: assert property ($fell(scl) |=> $stable(sda_s_oe_n))
    else $error("device data moved at clock fall");
  scl_high_a: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high too short");
  scl_low_a: assert property ($fell(scl) |-> !scl [*8])
    else $error("clock low too short");
  // both ends pulling at once during a bit is a fight
  no_fight_a: assert property (scl && !sda_s_oe_n |-> sda_m_oe_n)
    else $error("both ends drive data");
  idle_reset_a: assert property ($fell(rst) |-> scl && sda_s_oe_n && sda_m_oe_n)
    else $error("link not idle after reset");
  ack_c: cover property ($fell(sda_s_oe_n));
  start_c: cover property (scl && $fell(sda));
  stop_c: cover property (scl && $rose(sda));
endmodule
`default_nettype wire

// ### verification/test_dual_interface_tag_access_front.sv
`default_nettype none
module test_dual_interface_tag_access_front
  import dtaf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [3:0] ID = 4'h6; // arbitrary value
  localparam int WC = 20;
  localparam logic [7:0] SEL = {ID, BANK_USER, SEL_FIXED, 1'b0};
  logic           clock, rst, ce, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]     paddr;
  logic [31:0]    pwdata, prdata, rv, ev, mk, dw, rf_wdata, rf_rdata;
  logic [31:0]    qm[$], qe[$];
  logic [10:0]    a;
  logic [8:0]     rf_addr, rf_slots;
  logic           vcc_ok, field_ok, rf_rd, rf_wr, rf_cmd_active, dl4, hr, two, fast;
  logic           two_o, refused, act_out, act_oe_n, h_en, h_req, h_act, h_oe_n;
  dtaf_rate_t     rf_reply_rate;
  dtaf_activity_t act_sel;
  int             i, miscompares, compares;
  dtaf_link_if link ();
  dtaf_host #(.QUARTER(5)) i_dtaf_host (.clock(clock), .rst(rst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .link(link));
  dtaf_device #(.DEVICE_TYPE_ID(ID), .WRITE_CYCLES(WC)) i_dtaf_device (.clock(clock), .rst(rst),
    .ce(ce), .link(link), .vcc_ok(vcc_ok), .field_ok(field_ok), .rf_rd(rf_rd), .rf_wr(rf_wr),
    .rf_addr(rf_addr), .rf_wdata(rf_wdata), .rf_rdata(rf_rdata), .rf_cmd_active(rf_cmd_active),
    .rf_downlink_1of4(dl4), .rf_high_rate(hr), .rf_two_sub(two), .rf_fast_cmd(fast),
    .rf_slots(rf_slots), .rf_reply_rate(rf_reply_rate), .rf_reply_two_sub(two_o),
    .rf_fast_refused(refused), .activity_select(act_sel), .rf_activity_out(act_out),
    .rf_activity_oe_n(act_oe_n), .harvest_enable(h_en), .harvest_request(h_req),
    .harvest_active(h_act), .harvest_oe_n(h_oe_n));
  dtaf_link_sva i_dtaf_link_sva (.clock(clock), .rst(rst), .scl(link.scl), .sda_m_out(link.sda_m_out),
    .sda_m_oe_n(link.sda_m_oe_n), .sda_s_out(link.sda_s_out), .sda_s_oe_n(link.sda_s_oe_n), .sda(link.sda));

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, s, e);
    end
  endtask
  task automatic give_verdict();
    if (miscompares == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
      @(posedge clock);
    while (pready !== 1'b1);
    rv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // expectation noted first, the monitor compares when data appears
  task automatic rd(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] e);
    qm.push_back(m);
    qe.push_back(e & m);
    apb(1'b0, ad, 32'h0);
  endtask
  task automatic cmd(input logic [1:0] c, input logic [7:0] d, input logic ack);
    apb(1'b1, OFF_CMD, {16'h0, d, 5'h0, ack, c});
    do
      rd(OFF_STATUS, 32'h0, 32'h0);
    while (rv[STAT_BUSY_BIT] !== 1'b0);
  endtask
  task automatic wb(input logic [7:0] b, input logic nk);
    cmd(CMD_WRITE, b, 1'b0);
    rd(OFF_STATUS, 32'h2, {30'h0, nk, 1'b0});
  endtask
  task automatic rfrd(input logic [31:0] e);
    @(posedge clock);
    rf_rd <= 1'b1;
    rf_addr <= a[10:2];
    @(posedge clock);
    rf_rd <= 1'b0;
    @(posedge clock);
    check(rf_rdata, e);
  endtask

  always @(posedge clock)
    if (psel && penable && pready && !pwrite && qm.size() > 0)
    begin
      mk = qm.pop_front();
      if (mk != 32'h0)
        check(prdata & mk, qe.pop_front());
      else
        void'(qe.pop_front());
    end

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial
  begin
    #3000000;
    miscompares++;
    give_verdict();
  end

  initial
  begin
    {rst, vcc_ok, field_ok, rf_rd, rf_wr, rf_cmd_active, dl4, hr, two, fast, h_en, h_req} = 12'hc00;
    {psel, penable, pwrite, paddr, pwdata, rf_addr, rf_wdata} = '0;
    ce = 1'b1;
    act_sel = write_activity_setting;
    miscompares = 0;
    compares = 0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    void'($urandom(32'h1b2c516c));
    a = 11'($urandom) & 11'h7fc;
    dw = $urandom;
    apb(1'b1, OFF_INT_ENABLE, 32'h3);
    rd(OFF_INT_ENABLE, 32'hffffffff, 32'h3);
    apb(1'b0, 8'h20, 32'h0);
    check(pslverr, 1'b1);
    cmd(CMD_START, 8'h0, 1'b0);
    wb(SEL, 1'b0);
    wb({5'h0, a[10:8]}, 1'b0);
    wb(a[7:0], 1'b0);
    for (i = 0; i < 4; i++)
      wb(dw[8*i +: 8], 1'b0);
    cmd(CMD_STOP, 8'h0, 1'b0);
    // interrupt raised, masked, cleared
    apb(1'b1, OFF_INT_ENABLE, 32'h0);
    repeat (2) @(posedge clock);
    check(irq, 1'b0);
    apb(1'b1, OFF_INT_ENABLE, 32'h3);
    repeat (2) @(posedge clock);
    check(irq, 1'b1);
    apb(1'b1, OFF_INT_CLEAR, 32'h3);
    rd(OFF_INT_STATUS, 32'hffffffff, 32'h0);
    check(irq, 1'b0);
    // foreign type code, then wrong bank
    for (i = 0; i < 2; i++)
    begin
      cmd(CMD_START, 8'h0, 1'b0);
      wb(i ? (SEL | 8'h08) : (SEL ^ 8'h10), 1'b1);
      cmd(CMD_STOP, 8'h0, 1'b0);
    end
    cmd(CMD_START, 8'h0, 1'b0);
    wb(SEL, 1'b0);
    wb({5'h0, a[10:8]}, 1'b0);
    wb(a[7:0], 1'b0);
    cmd(CMD_START, 8'h0, 1'b0);
    wb(SEL | 8'h01, 1'b0);
    for (i = 0; i < 4; i++)
    begin
      cmd(CMD_READ, 8'h0, i == 3);
      rd(OFF_STATUS, 32'hff02, {16'h0, dw[8*i +: 8], 6'h0, i == 3, 1'b0});
    end
    cmd(CMD_STOP, 8'h0, 1'b0);
    rfrd(dw);
    ev = $urandom;
    // first without supply: indicator must stay released
    for (i = 0; i < 2; i++)
    begin
      vcc_ok <= i[0];
      repeat (6) @(posedge clock);
      rf_wr <= 1'b1;
      rf_addr <= a[10:2];
      rf_wdata <= ev;
      @(posedge clock);
      rf_wr <= 1'b0;
      repeat (4) @(posedge clock);
      check({act_out, act_oe_n}, {1'b0, !i[0]});
      // a write during the timer is dropped
      rf_wr <= 1'b1;
      rf_wdata <= ~ev;
      @(posedge clock);
      rf_wr <= 1'b0;
      repeat (WC + 4) @(posedge clock);
      check(act_oe_n, 1'b1);
    end
    rfrd(ev);
    act_sel <= command_activity_setting;
    rf_cmd_active <= 1'b1;
    repeat (3) @(posedge clock);
    check(act_oe_n, 1'b0);
    // clock enable low freezes the indicator
    ce <= 1'b0;
    rf_cmd_active <= 1'b0;
    repeat (3) @(posedge clock);
    check(act_oe_n, 1'b0);
    ce <= 1'b1;
    repeat (3) @(posedge clock);
    check(act_oe_n, 1'b1);
    // harvest dropped by field loss, then by disable
    for (i = 0; i < 2; i++)
    begin
      h_en <= 1'b1;
      field_ok <= 1'b1;
      repeat (5) @(posedge clock);
      h_req <= 1'b1;
      @(posedge clock);
      h_req <= 1'b0;
      repeat (3) @(posedge clock);
      check({h_act, h_oe_n}, 2'b10);
      h_en <= i[0] ? 1'b0 : 1'b1;
      field_ok <= i[0];
      repeat (6) @(posedge clock);
      check({h_act, h_oe_n}, 2'b01);
    end
    for (i = 0; i < 16; i++)
    begin
      {dl4, hr, two, fast} <= i[3:0];
      repeat (3) @(posedge clock);
      check(rf_slots, i[3] ? SLOTS_1OF4 : SLOTS_1OF256);
      check(rf_reply_rate, (i[0] && i[2] && !i[1]) ? RATE_FAST : i[2] ? RATE_HIGH : RATE_LOW);
      check({two_o, refused}, {i[1], i[0] && (!i[2] || i[1])});
    end
    give_verdict();
  end
endmodule
`default_nettype wire
